// *** shared/mask_probe_pkg.sv ***
package mask_probe_pkg;

  // operand sources that the decoder can select
  typedef enum logic [2:0] {OPK_REG, OPK_REGIND, OPK_PTR, OPK_ABS, OPK_IMM} opkind_t;
  typedef enum logic [1:0] {STEP_NONE, STEP_POST, STEP_PRE} step_t;

  // one decoded addressing combination
  typedef struct packed {
    logic       legal;
    logic       wordOp;
    opkind_t    dstKind;
    opkind_t    srcKind;
    step_t      step;
    logic       stepDst;
    logic       useOfs;
    logic [5:0] cycles;
  } desc_t;

  // flag byte layout
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam int SIGN_BYTE = 7;
  localparam int SIGN_WORD = 15;

  // extension codes
  localparam logic [3:0] XTN_PROBE    = 4'ha;
  localparam logic [7:0] XTN_PROBE_NN = 8'ha1;

  // pointer step sizes
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // cycle counts per addressing combination
  localparam logic [5:0] CYC_6  = 6'h06;
  localparam logic [5:0] CYC_10 = 6'h0a;
  localparam logic [5:0] CYC_12 = 6'h0c;
  localparam logic [5:0] CYC_14 = 6'h0e;
  localparam logic [5:0] CYC_16 = 6'h10;
  localparam logic [5:0] CYC_18 = 6'h12;
  localparam logic [5:0] CYC_20 = 6'h14;
  localparam logic [5:0] CYC_22 = 6'h16;
  localparam logic [5:0] CYC_24 = 6'h18;
  localparam logic [5:0] CYC_26 = 6'h1a;
  localparam logic [5:0] CYC_28 = 6'h1c;
  localparam logic [5:0] CYC_30 = 6'h1e;

  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

endpackage

// *** shared/probe_dec_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface probe_dec_if;
  logic [7:0]                  opcode;
  logic [7:0]                  ext;
  logic                        selBit;
  mask_probe_pkg::desc_t       desc;
  modport dec  (input opcode, input ext, input selBit, output desc);
  modport core (output opcode, output ext, output selBit, input desc);
endinterface
`default_nettype wire

// *** verilog/mask_probe_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module mask_probe_decode (
  // decoder side of the request carrier
  probe_dec_if.dec dec
);
  // short aliases keep the table to one entry per form
  localparam mask_probe_pkg::opkind_t RG = mask_probe_pkg::OPK_REG;
  localparam mask_probe_pkg::opkind_t RI = mask_probe_pkg::OPK_REGIND;
  localparam mask_probe_pkg::opkind_t PT = mask_probe_pkg::OPK_PTR;
  localparam mask_probe_pkg::opkind_t AB = mask_probe_pkg::OPK_ABS;
  localparam mask_probe_pkg::opkind_t IM = mask_probe_pkg::OPK_IMM;
  localparam mask_probe_pkg::step_t   NO = mask_probe_pkg::STEP_NONE;
  localparam mask_probe_pkg::step_t   PO = mask_probe_pkg::STEP_POST;
  localparam mask_probe_pkg::step_t   PR = mask_probe_pkg::STEP_PRE;

  // one legal table entry
  function automatic mask_probe_pkg::desc_t form(
      input logic                    wd,
      input mask_probe_pkg::opkind_t dk,
      input mask_probe_pkg::opkind_t sk,
      input mask_probe_pkg::step_t   sp,
      input logic                    sd,
      input logic                    of,
      input logic [5:0]              cy);
    mask_probe_pkg::desc_t r;
    r         = '0;
    r.legal   = 1'b1;
    r.wordOp  = wd;
    r.dstKind = dk;
    r.srcKind = sk;
    r.step    = sp;
    r.stepDst = sd;
    r.useOfs  = of;
    r.cycles  = cy;
    return r;
  endfunction

  // opcode plus extension pick the form; anything unlisted stays refused
  always_comb begin
    mask_probe_pkg::desc_t d;
    logic                  xa;
    logic                  sb;
    d  = '0;
    xa = (dec.ext[7:4] == mask_probe_pkg::XTN_PROBE);
    sb = dec.selBit;
    case (dec.opcode)
      // byte forms, no extension byte
      8'ha2: d = form(1'b0, RG, RG, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_6);
      8'ha3: d = form(1'b0, RG, RI, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_6);
      8'ha4: d = form(1'b0, RG, RG, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_10);
      8'ha5: d = form(1'b0, RG, IM, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_10);
      // byte forms qualified by the extension
      8'he6: if (xa) d = form(1'b0, RI, RG, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_10);
      8'he7: if (xa) d = form(1'b0, RG, RI, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_10);
      8'h72: if (xa) d = form(1'b0, sb ? RG : PT, sb ? PT : RG, NO, 1'b0, 1'b0,
                              sb ? mask_probe_pkg::CYC_12 : mask_probe_pkg::CYC_18);
      8'hb4: if (xa) d = form(1'b0, sb ? RG : PT, sb ? PT : RG, PO, !sb, 1'b0,
                              sb ? mask_probe_pkg::CYC_16 : mask_probe_pkg::CYC_22);
      8'hc2: if (xa) d = form(1'b0, sb ? RG : PT, sb ? PT : RG, PR, !sb, 1'b0,
                              sb ? mask_probe_pkg::CYC_16 : mask_probe_pkg::CYC_22);
      8'h7f: if (xa) d = form(1'b0, RG, PT, NO, 1'b0, 1'b1,
                              sb ? mask_probe_pkg::CYC_24 : mask_probe_pkg::CYC_26);
      8'h26: if (xa) d = form(1'b0, PT, RG, NO, 1'b0, 1'b1,
                              sb ? mask_probe_pkg::CYC_26 : mask_probe_pkg::CYC_28);
      8'hc4: if (xa) d = form(1'b0, RG, AB, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_18);
      8'hc5: if (xa) d = form(1'b0, AB, RG, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_20);
      8'h73: if (xa) d = form(1'b0, PT, PT, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_18);
      8'hf3: if (xa) d = form(1'b0, PT, IM, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_16);
      8'h2f: begin
        // the only form whose whole extension byte is fixed
        if (dec.ext == mask_probe_pkg::XTN_PROBE_NN) begin
          d = form(1'b0, AB, IM, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_22);
        end
      end
      // word forms
      8'hae: d = form(1'b1, RG, sb ? PT : RG, NO, 1'b0, 1'b0,
                      sb ? mask_probe_pkg::CYC_16 : mask_probe_pkg::CYC_10);
      8'ha7: d = form(1'b1, RG, RG, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_12);
      8'h96: if (xa) d = form(1'b1, RI, RG, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_14);
      8'ha6: if (xa) d = form(1'b1, RG, RI, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_14);
      8'h7e: if (xa) d = form(1'b1, RG, PT, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_18);
      8'hd5: if (xa) d = form(1'b1, RG, PT, PO, 1'b0, 1'b0, mask_probe_pkg::CYC_22);
      8'hc3: if (xa) d = form(1'b1, RG, PT, PR, 1'b0, 1'b0, mask_probe_pkg::CYC_24);
      8'h86: if (xa) d = form(1'b1, RG, PT, NO, 1'b0, 1'b1,
                              sb ? mask_probe_pkg::CYC_28 : mask_probe_pkg::CYC_30);
      8'he2: if (xa) d = form(1'b1, RG, AB, NO, 1'b0, 1'b0, mask_probe_pkg::CYC_22);
      default: d = '0;
    endcase
    dec.desc = d;
  end
endmodule // mask_probe_decode
`default_nettype wire

// *** verilog/mask_probe_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module mask_probe_exec (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // instruction request
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  opExt,
  input  wire logic        selBit,
  input  wire logic [7:0]  dstField,
  input  wire logic [7:0]  srcField,
  input  wire logic [15:0] offset,
  input  wire logic [15:0] immValue,
  output var  logic        busy,
  output var  logic        done,
  output var  logic        illegal,
  // flags
  input  wire logic [7:0]  flagsIn,
  output var  logic [7:0]  flagsOut,
  output var  logic        flagWe,
  // register file
  output var  logic [7:0]  rfAddr,
  input  wire logic [7:0]  rfRdata,
  output var  logic        rfWe,
  output var  logic [7:0]  rfWaddr,
  output var  logic [7:0]  rfWdata,
  // data memory
  output var  logic        memReq,
  output var  logic [15:0] memAddr,
  input  wire logic        memAck,
  input  wire logic [7:0]  memRdata
);
  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_INDRD, S_REGRD, S_PTRHI, S_PTRLO, S_PTRWR, S_MEMRD, S_TEST, S_WAIT
  } fsm_t;

  typedef struct packed {
    fsm_t                  fsm;
    logic                  opIdx;
    logic                  byteIdx;
    logic                  postDone;
    logic [15:0]           addr;
    logic [15:0]           ptr;
    logic [15:0]           dstVal;
    logic [15:0]           srcVal;
    logic [7:0]            dstFld;
    logic [7:0]            srcFld;
    logic [15:0]           ofs;
    logic [15:0]           imm;
    mask_probe_pkg::desc_t d;
    logic [5:0]            cyc;
    logic                  memReq;
    logic                  rfWe;
    logic [7:0]            rfWaddr;
    logic [7:0]            rfWdata;
    logic [7:0]            flags;
    logic                  flagWe;
    logic                  done;
    logic                  illegal;
  } state_t;

  state_t          st;
  state_t          nx;
  probe_dec_if     decBus ();
  logic [15:0]     testRes;

  // decoder sees the raw request; only sampled at start
  assign decBus.opcode = opcode;
  assign decBus.ext    = opExt;
  assign decBus.selBit = selBit;

  mask_probe_decode u_decode (
    .dec (decBus.dec)
  );

  // masked result; the word form keeps all 16 bits, the byte form only the low 8
  assign testRes = st.dstVal & st.srcVal & (st.d.wordOp ? 16'hffff : 16'h00ff);

  // next-state logic
  always_comb begin
    logic                       opDone;
    logic                       stepHere;
    logic                       lastByte;
    logic [15:0]                stepAmt;
    logic [15:0]                shifted;
    logic [15:0]                p;
    logic [7:0]                 fld;
    logic [7:0]                 stepFld;
    mask_probe_pkg::opkind_t    kind;
    opDone   = 1'b0;
    nx       = st;
    nx.flagWe = 1'b0;
    nx.done  = 1'b0;
    nx.rfWe  = 1'b0;
    kind     = st.opIdx ? st.d.srcKind : st.d.dstKind;
    fld      = st.opIdx ? st.srcFld : st.dstFld;
    stepFld  = st.d.stepDst ? st.dstFld : st.srcFld;
    stepHere = (st.d.step != mask_probe_pkg::STEP_NONE) && (st.d.stepDst == !st.opIdx);
    stepAmt  = st.d.wordOp ? mask_probe_pkg::STEP_WORD : mask_probe_pkg::STEP_BYTE;
    lastByte = !st.d.wordOp || st.byteIdx;
    shifted  = st.opIdx ? st.srcVal : st.dstVal;
    shifted  = {shifted[7:0], (st.fsm == S_MEMRD) ? memRdata : rfRdata};
    p        = {st.ptr[15:8], rfRdata};
    if (st.fsm != S_IDLE && st.cyc != 6'h3f) begin
      nx.cyc = 6'(st.cyc + 6'h01);
    end
    case (st.fsm)
      S_IDLE: begin
        if (start) begin
          nx.d        = decBus.desc;
          nx.dstFld   = dstField;
          nx.srcFld   = srcField;
          nx.ofs      = offset;
          nx.imm      = immValue;
          nx.cyc      = 6'h01;
          nx.opIdx    = 1'b0;
          nx.postDone = 1'b0;
          nx.illegal  = !decBus.desc.legal;
          nx.done     = !decBus.desc.legal;
          nx.fsm      = decBus.desc.legal ? S_SETUP : S_IDLE;
        end
      end
      S_SETUP: begin
        nx.byteIdx = 1'b0;
        if (st.opIdx) nx.srcVal = mask_probe_pkg::RST_WORD;
        else          nx.dstVal = mask_probe_pkg::RST_WORD;
        case (kind)
          mask_probe_pkg::OPK_REG: begin
            nx.addr = {8'h00, st.d.wordOp ? {fld[7:1], 1'b0} : fld};
            nx.fsm  = S_REGRD;
          end
          mask_probe_pkg::OPK_REGIND: begin
            nx.addr = {8'h00, fld};
            nx.fsm  = S_INDRD;
          end
          mask_probe_pkg::OPK_PTR: begin
            nx.addr = {8'h00, fld[7:1], 1'b0};
            nx.fsm  = S_PTRHI;
          end
          mask_probe_pkg::OPK_ABS: begin
            nx.addr   = st.ofs;
            nx.memReq = 1'b1;
            nx.fsm    = S_MEMRD;
          end
          default: begin // immediate mask from the instruction stream
            if (st.opIdx) nx.srcVal = st.d.wordOp ? st.imm : {8'h00, st.imm[7:0]};
            else          nx.dstVal = st.d.wordOp ? st.imm : {8'h00, st.imm[7:0]};
            opDone = 1'b1;
          end
        endcase
      end
      S_INDRD: begin
        nx.addr = {8'h00, rfRdata};
        nx.fsm  = S_REGRD;
      end
      S_REGRD: begin
        if (st.opIdx) nx.srcVal = shifted;
        else          nx.dstVal = shifted;
        nx.addr    = 16'(st.addr + 16'h0001);
        nx.byteIdx = 1'b1;
        opDone     = lastByte;
      end
      S_PTRHI: begin
        nx.ptr  = {rfRdata, st.ptr[7:0]};
        nx.addr = 16'(st.addr + 16'h0001);
        nx.fsm  = S_PTRLO;
      end
      S_PTRLO: begin
        // step first so the operand read uses the decremented address
        if (stepHere && st.d.step == mask_probe_pkg::STEP_PRE) begin
          p = 16'(p - stepAmt);
        end
        nx.ptr     = p;
        nx.byteIdx = 1'b0;
        if (stepHere && st.d.step == mask_probe_pkg::STEP_PRE) begin
          nx.fsm = S_PTRWR;
        end else begin
          nx.addr   = 16'(p + (st.d.useOfs ? st.ofs : 16'h0000));
          nx.memReq = 1'b1;
          nx.fsm    = S_MEMRD;
        end
      end
      S_PTRWR: begin
        // the pointer pair is the only thing ever written back
        nx.rfWe    = 1'b1;
        nx.rfWaddr = {stepFld[7:1], st.byteIdx};
        nx.rfWdata = st.byteIdx ? st.ptr[7:0] : st.ptr[15:8];
        nx.byteIdx = 1'b1;
        if (st.byteIdx && st.postDone) begin
          nx.fsm = S_WAIT;
        end else if (st.byteIdx) begin
          nx.byteIdx = 1'b0;
          nx.addr    = 16'(st.ptr + (st.d.useOfs ? st.ofs : 16'h0000));
          nx.memReq  = 1'b1;
          nx.fsm     = S_MEMRD;
        end
      end
      S_MEMRD: begin
        if (memAck) begin
          if (st.opIdx) nx.srcVal = shifted;
          else          nx.dstVal = shifted;
          nx.addr    = 16'(st.addr + 16'h0001);
          nx.byteIdx = 1'b1;
          nx.memReq  = !lastByte;
          opDone     = lastByte;
        end
      end
      S_TEST: begin
        nx.flags = flagsIn;
        nx.flags[mask_probe_pkg::FLAG_Z] = (testRes == 16'h0000);
        nx.flags[mask_probe_pkg::FLAG_S] = st.d.wordOp ? testRes[mask_probe_pkg::SIGN_WORD]
                                                       : testRes[mask_probe_pkg::SIGN_BYTE];
        nx.flags[mask_probe_pkg::FLAG_V] = 1'b0;
        nx.flagWe = 1'b1;
        if (st.d.step == mask_probe_pkg::STEP_POST) begin
          nx.ptr      = 16'(st.ptr + stepAmt);
          nx.postDone = 1'b1;
          nx.byteIdx  = 1'b0;
          nx.fsm      = S_PTRWR;
        end else begin
          nx.fsm = S_WAIT;
        end
      end
      S_WAIT: begin
        // slow memory may already have used up the budget; then finish at once
        if (6'(st.cyc + 6'h01) >= st.d.cycles) begin
          nx.done = 1'b1;
          nx.fsm  = S_IDLE;
        end
      end
      default: nx.fsm = S_IDLE;
    endcase
    if (opDone) begin
      nx.byteIdx = 1'b0;
      nx.opIdx   = 1'b1;
      nx.fsm     = st.opIdx ? S_TEST : S_SETUP;
    end
  end

  // single state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st     <= '0;
      st.fsm <= S_IDLE;
    end else begin
      st <= nx;
    end
  end

  assign busy     = (st.fsm != S_IDLE);
  assign done     = st.done;
  assign illegal  = st.illegal;
  assign flagsOut = st.flags;
  assign flagWe   = st.flagWe;
  assign rfAddr   = st.addr[7:0];
  assign rfWe     = st.rfWe;
  assign rfWaddr  = st.rfWaddr;
  assign rfWdata  = st.rfWdata;
  assign memReq   = st.memReq;
  assign memAddr  = st.addr;

  // checks on the flag update, pointer stepping and cycle count
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence sTestStep;
    st.fsm == S_TEST;
  endsequence
  sequence sPairWrite;
    rfWe ##1 rfWe;
  endsequence

  AST_ZERO_FLAG: assert property (sTestStep |=> flagWe &&
    flagsOut[mask_probe_pkg::FLAG_Z] == ($past(testRes) == 16'h0000))
    else $error("zero flag does not follow masked result");
  AST_SIGN_BYTE: assert property (sTestStep ##0 !st.d.wordOp |=>
    flagsOut[mask_probe_pkg::FLAG_S] == $past(st.dstVal[7] & st.srcVal[7]))
    else $error("byte sign flag wrong");
  AST_SIGN_WORD: assert property (sTestStep ##0 st.d.wordOp |=>
    flagsOut[mask_probe_pkg::FLAG_S] == $past(st.dstVal[15] & st.srcVal[15]))
    else $error("word sign flag wrong");
  AST_FLAGS_KEPT: assert property (sTestStep |=> !flagsOut[mask_probe_pkg::FLAG_V] &&
    flagsOut[mask_probe_pkg::FLAG_C] == $past(flagsIn[mask_probe_pkg::FLAG_C]) &&
    flagsOut[mask_probe_pkg::FLAG_H] == $past(flagsIn[mask_probe_pkg::FLAG_H]))
    else $error("overflow not cleared or other flags disturbed");
  AST_NO_WRITEBACK: assert property (rfWe |-> st.d.step != mask_probe_pkg::STEP_NONE)
    else $error("register write without pointer stepping");
  AST_POST_AFTER: assert property (sTestStep ##0 st.d.step == mask_probe_pkg::STEP_POST
    |=> ##1 sPairWrite)
    else $error("post-increment write missing after test");
  AST_PRE_BEFORE: assert property (rfWe && st.d.step == mask_probe_pkg::STEP_PRE
    |-> !flagWe && st.fsm != S_WAIT)
    else $error("pre-decrement written after test");
  AST_STEP_SIZE: assert property (sTestStep ##0 st.d.step == mask_probe_pkg::STEP_POST |=>
    st.ptr == 16'($past(st.ptr) + (st.d.wordOp ? 16'h0002 : 16'h0001)))
    else $error("pointer step size wrong");
  AST_CYCLE_COUNT: assert property (done && !illegal |-> st.cyc >= st.d.cycles)
    else $error("instruction finished before its cycle count");

endmodule // mask_probe_exec
`default_nettype wire

// *** sim/core_store_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_store_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // register file
  input  wire logic [7:0]  rfAddr,
  output var  logic [7:0]  rfRdata,
  input  wire logic        rfWe,
  input  wire logic [7:0]  rfWaddr,
  input  wire logic [7:0]  rfWdata,
  // data memory
  input  wire logic        memReq,
  input  wire logic [15:0] memAddr,
  output var  logic        memAck,
  output var  logic [7:0]  memRdata,
  // wait states before each ack
  input  wire logic [3:0]  ackWait
);
  logic [7:0] regFile [0:255];
  logic [7:0] dataMem [0:65535];
  logic [3:0] waitCnt;
  int         wrCount = 0;

  // reads answer in the same cycle
  assign rfRdata = regFile[rfAddr];

  // counting writes exposes any write-back beyond the pointer pairs
  always @(posedge sys_clk) begin
    if (rfWe === 1'b1) begin
      regFile[rfWaddr] <= rfWdata;
      wrCount <= wrCount + 1;
    end
  end

  // one ack per request; data is garbage outside the ack cycle
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memAck <= 1'b0;
      memRdata <= 8'h5a;
      waitCnt <= 4'h0;
    end else if (memReq && !memAck && waitCnt >= ackWait) begin
      memAck <= 1'b1;
      memRdata <= dataMem[memAddr];
      waitCnt <= 4'h0;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata; // inverse of last value, never a stale match
      if (memReq && !memAck) begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule // core_store_model
`default_nettype wire

// *** sim/mask_probe_exec_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module mask_probe_exec_bench;
  logic        sys_clk, rst_b, start, selBit, busy, done, illegal, flagWe;
  logic        rfWe, memReq, memAck;
  logic [7:0]  opcode, opExt, dstField, srcField, flagsIn, flagsOut;
  logic [7:0]  rfAddr, rfRdata, rfWaddr, rfWdata, memRdata;
  logic [15:0] offset, immValue, memAddr;
  logic [3:0]  ackWait;
  int          fail_count = 0;
  int          samples_checked = 0;

  mask_probe_exec mask_probe_exec_inst (.sys_clk(sys_clk), .rst_b(rst_b), .start(start),
    .opcode(opcode), .opExt(opExt), .selBit(selBit), .dstField(dstField),
    .srcField(srcField), .offset(offset), .immValue(immValue), .busy(busy), .done(done),
    .illegal(illegal), .flagsIn(flagsIn), .flagsOut(flagsOut), .flagWe(flagWe),
    .rfAddr(rfAddr), .rfRdata(rfRdata), .rfWe(rfWe), .rfWaddr(rfWaddr), .rfWdata(rfWdata),
    .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata));
  core_store_model core_store_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .rfAddr(rfAddr), .rfRdata(rfRdata), .rfWe(rfWe), .rfWaddr(rfWaddr), .rfWdata(rfWdata),
    .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata),
    .ackWait(ackWait));

  // 10 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // big-endian pair: high byte at the even register
  task automatic setPair(input logic [7:0] a, input logic [15:0] v);
    core_store_model_inst.regFile[a & 8'hfe] = v[15:8];
    core_store_model_inst.regFile[a | 8'h01] = v[7:0];
  endtask

  function automatic logic [15:0] pairOf(input logic [7:0] a);
    return {core_store_model_inst.regFile[a & 8'hfe], core_store_model_inst.regFile[a | 8'h01]};
  endfunction

  task automatic setMem(input logic [15:0] a, input logic [7:0] v);
    core_store_model_inst.dataMem[a] = v;
  endtask

  // one instruction; cyc of 1 means a refused opcode
  task automatic run_op(input logic [7:0] op, xt, input logic sl, input logic [7:0] df, sf,
      input logic wd, input logic [15:0] dv, mv, input int cyc, wr, input logic slow);
    logic [15:0] res;
    logic [7:0]  ef;
    logic        sawWe;
    int          n;
    int          w0;
    w0 = core_store_model_inst.wrCount;
    res = wd ? (dv & mv) : {8'h00, dv[7:0] & mv[7:0]};
    flagsIn = (flagsIn === 8'h9c) ? 8'h70 : 8'h9c; // alternate so every flag but V both ways; V stays set
    ef = flagsIn;
    ef[mask_probe_pkg::FLAG_Z] = (res == 16'h0000);
    ef[mask_probe_pkg::FLAG_S] = wd ? res[mask_probe_pkg::SIGN_WORD]
                                    : res[mask_probe_pkg::SIGN_BYTE];
    ef[mask_probe_pkg::FLAG_V] = 1'b0;
    opcode = op;
    opExt = xt;
    selBit = sl;
    dstField = df;
    srcField = sf;
    immValue = mv;
    ackWait = slow ? 4'hf : 4'h0; // long enough to overrun the cycle budget
    start = 1'b1;
    @(posedge sys_clk);
    #1;
    start = 1'b0;
    n = 0;
    sawWe = 1'b0;
    while (n < 200 && done !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (flagWe === 1'b1) sawWe = 1'b1;
      // a second request while busy must be ignored
      if (n == 2) begin
        start = 1'b1;
        opcode = 8'h60;
      end
      if (n == 3) start = 1'b0;
    end
    check("done seen", {15'h0000, done}, 16'h0001);
    if (cyc == 1) begin
      check("illegal", {15'h0000, illegal}, 16'h0001);
      check("illegal latency", 16'(n), 16'h0000);
    end else begin
      check("illegal", {15'h0000, illegal}, 16'h0000);
      check("busy after done", {15'h0000, busy}, 16'h0000);
      check("flags", {8'h00, flagsOut}, {8'h00, ef});
      check("flag write", {15'h0000, sawWe}, 16'h0001);
      check("reg writes", 16'(core_store_model_inst.wrCount - w0), 16'(wr));
      // start cycle counts as the first, so done shows cyc - 1 edges after it
      check("cycles", {15'h0000, slow ? (n >= cyc) : (n == cyc - 1)}, 16'h0001);
    end
  endtask

  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    opcode = 8'h00;
    opExt = 8'h00;
    selBit = 1'b0;
    dstField = 8'h00;
    srcField = 8'h00;
    offset = 16'h0000;
    immValue = 16'h0000;
    flagsIn = 8'h9c;
    ackWait = 4'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    check("idle outputs", {13'h0000, busy, done, flagWe}, 16'h0000);
    // byte register forms, zero then sign
    core_store_model_inst.regFile[8'h40] = 8'h4c;
    core_store_model_inst.regFile[8'h41] = 8'h33;
    run_op(8'ha4, 8'ha0, 1'b1, 8'h40, 8'h41, 1'b0, 16'h004c, 16'h0033, 10, 0, 1'b0);
    check("dst kept", {8'h00, core_store_model_inst.regFile[8'h40]}, 16'h004c);
    core_store_model_inst.regFile[8'h42] = 8'hcc;
    core_store_model_inst.regFile[8'h43] = 8'h80;
    run_op(8'ha4, 8'ha0, 1'b1, 8'h42, 8'h43, 1'b0, 16'h00cc, 16'h0080, 10, 0, 1'b0);
    core_store_model_inst.regFile[8'h44] = 8'hec;
    run_op(8'ha5, 8'ha0, 1'b1, 8'h44, 8'h00, 1'b0, 16'h00ec, 16'h0020, 10, 0, 1'b0);
    // absolute and indirect memory sources
    offset = 16'h0fbc;
    setMem(16'h0fbc, 8'h85);
    core_store_model_inst.regFile[8'h45] = 8'hcc;
    run_op(8'hc4, 8'ha0, 1'b1, 8'h45, 8'h00, 1'b0, 16'h00cc, 16'h0085, 18, 0, 1'b0);
    setPair(8'h10, 16'h1234);
    setMem(16'h1234, 8'h0f);
    core_store_model_inst.regFile[8'h46] = 8'hf0;
    run_op(8'h72, 8'ha0, 1'b1, 8'h46, 8'h10, 1'b0, 16'h00f0, 16'h000f, 12, 0, 1'b0);
    // pointer stepping across a byte boundary
    setPair(8'h12, 16'h20ff);
    setMem(16'h20ff, 8'h81);
    core_store_model_inst.regFile[8'h47] = 8'h01;
    run_op(8'hb4, 8'ha0, 1'b1, 8'h47, 8'h12, 1'b0, 16'h0001, 16'h0081, 16, 2, 1'b0);
    check("post pointer", pairOf(8'h12), 16'h2100);
    setPair(8'h14, 16'h3000);
    setMem(16'h2fff, 8'h80);
    setMem(16'h3000, 8'h00);
    core_store_model_inst.regFile[8'h48] = 8'hff;
    run_op(8'hc2, 8'ha0, 1'b1, 8'h48, 8'h14, 1'b0, 16'h00ff, 16'h0080, 16, 2, 1'b0);
    check("pre pointer", pairOf(8'h14), 16'h2fff);
    // memory destination, slow memory on the first
    setPair(8'h16, 16'h4000);
    setMem(16'h4000, 8'h55);
    core_store_model_inst.regFile[8'h49] = 8'haa;
    run_op(8'hb4, 8'ha0, 1'b0, 8'h16, 8'h49, 1'b0, 16'h0055, 16'h00aa, 22, 2, 1'b1);
    check("mem dst post", pairOf(8'h16), 16'h4001);
    setPair(8'h18, 16'h4100);
    setMem(16'h40ff, 8'h3c);
    core_store_model_inst.regFile[8'h4a] = 8'h0c;
    run_op(8'hc2, 8'ha0, 1'b0, 8'h18, 8'h4a, 1'b0, 16'h003c, 16'h000c, 22, 2, 1'b0);
    check("mem dst pre", pairOf(8'h18), 16'h40ff);
    setPair(8'h1a, 16'h0af0);
    setMem(16'h0af0, 8'hcc);
    setPair(8'h1c, 16'h1068);
    setMem(16'h1068, 8'h33);
    run_op(8'h73, 8'ha0, 1'b0, 8'h1a, 8'h1c, 1'b0, 16'h00cc, 16'h0033, 18, 0, 1'b0);
    setPair(8'h1e, 16'h0fbc);
    setMem(16'h0fbc, 8'hec);
    run_op(8'hf3, 8'ha0, 1'b0, 8'h1e, 8'h00, 1'b0, 16'h00ec, 16'h0020, 16, 0, 1'b0);
    // word forms
    setPair(8'h50, 16'h8001);
    setPair(8'h52, 16'h8000);
    run_op(8'ha7, 8'ha0, 1'b1, 8'h50, 8'h52, 1'b1, 16'h8001, 16'h8000, 12, 0, 1'b0);
    core_store_model_inst.regFile[8'h4b] = 8'h60;
    setPair(8'h60, 16'h3333);
    setPair(8'h54, 16'hcccc);
    run_op(8'h96, 8'ha0, 1'b0, 8'h4b, 8'h54, 1'b1, 16'h3333, 16'hcccc, 14, 0, 1'b0);
    setPair(8'h20, 16'h40fe);
    setMem(16'h40fe, 8'h12);
    setMem(16'h40ff, 8'h34);
    setPair(8'h56, 16'h00ff);
    run_op(8'hd5, 8'ha0, 1'b1, 8'h56, 8'h20, 1'b1, 16'h00ff, 16'h1234, 22, 2, 1'b0);
    check("word post", pairOf(8'h20), 16'h4100);
    setPair(8'h22, 16'h5000);
    setMem(16'h4ffe, 8'h80);
    setMem(16'h4fff, 8'h00);
    setPair(8'h58, 16'hffff);
    run_op(8'hc3, 8'ha0, 1'b1, 8'h58, 8'h22, 1'b1, 16'hffff, 16'h8000, 24, 2, 1'b0);
    check("word pre", pairOf(8'h22), 16'h4ffe);
    // indirect register, indexed and absolute forms
    core_store_model_inst.regFile[8'h4d] = 8'h4e;
    core_store_model_inst.regFile[8'h4e] = 8'h8c;
    core_store_model_inst.regFile[8'h4f] = 8'h84;
    run_op(8'he6, 8'ha0, 1'b1, 8'h4d, 8'h4f, 1'b0, 16'h008c, 16'h0084, 10, 0, 1'b0);
    offset = 16'h1010;
    setPair(8'h24, 16'h1000);
    setMem(16'h1010, 8'hf0);
    setMem(16'h1011, 8'h0f);
    core_store_model_inst.regFile[8'h4c] = 8'h0f;
    run_op(8'h7f, 8'ha0, 1'b1, 8'h4c, 8'h24, 1'b0, 16'h000f, 16'h00f0, 24, 0, 1'b0);
    run_op(8'h2f, 8'ha1, 1'b0, 8'h00, 8'h00, 1'b0, 16'h00f0, 16'h0080, 22, 0, 1'b0);
    setPair(8'h5a, 16'h0ff0);
    run_op(8'he2, 8'ha0, 1'b1, 8'h5a, 8'h00, 1'b1, 16'h0ff0, 16'hf00f, 22, 0, 1'b0);
    // refused encodings
    run_op(8'h60, 8'ha0, 1'b1, 8'h40, 8'h41, 1'b0, 16'h0000, 16'h0000, 1, 0, 1'b0);
    run_op(8'h72, 8'h50, 1'b1, 8'h40, 8'h10, 1'b0, 16'h0000, 16'h0000, 1, 0, 1'b0);
    test_done();
  end

  // about thirty times the expected run length
  initial begin
    #1_000_000;
    fail_count++;
    test_done();
  end
endmodule // mask_probe_exec_bench
`default_nettype wire
